// >>> src/gpodc_cfg.svh
// constants for the gpio output drive configuration block
// Behaviour
// (R1) The drive-type register sits at offset 0x04 and clears to all zeros on reset.
// (R2) Both registers accept byte, half-word and word writes and change only the enabled bytes.
// (R3) Drive-type bit y in the low sixteen bits controls pin y, for pins 0 to 15.
// (R4) A drive-type bit of 0 means push-pull and 1 means open-drain, with 0 after reset.
// (R5) Software keeps the upper sixteen drive-type bits at zero when it writes.
// (R6) Drive-type bits and speed fields change only on a software write.
// (R7) The speed register sits at offset 0x08 and resets to 0x0C000000 on port A, zero elsewhere.
// (R8) Pin y's two-bit speed field occupies bits 2y+1 down to 2y.
// (R9) Speed code x0 is 2 MHz, 01 is 10 MHz and 11 is 50 MHz.
// (R10) An open-drain pin is pulled low for data 0 and released for data 1.
// (R11) A push-pull pin is driven to its data level, low or high.
// (R12) Drive settings act only in general output or alternate function mode; otherwise the buffer is off.
// (R13) The upper half of the drive-type register reads zero and ignores writes.
`ifndef GPODC_CFG_SVH
`define GPODC_CFG_SVH
// ****************************************
// register map
// ****************************************
`define GPODC_OFS_DRIVE 8'h04
`define GPODC_OFS_SLEW 8'h08
`define GPODC_DRIVE_RST 32'h0000_0000
`define GPODC_SLEW_RST_A 32'h0C00_0000
`define GPODC_SLEW_RST 32'h0000_0000
`define GPODC_DRIVE_MASK 32'h0000_FFFF
`define GPODC_RD_ZERO 32'h0000_0000
// ****************************************
// field encodings
// ****************************************
`define GPODC_OD_BIT 1'b1
`define GPODC_PINS 16
`endif

// >>> src/gpodc_pkg.sv
// types and helpers for the gpio output drive configuration block
`default_nettype none
package gpodc_pkg;
	// pin function field codes
	typedef enum logic [1:0] {
		GPODC_FN_INPUT = 2'b00,
		GPODC_FN_GPO = 2'b01,
		GPODC_FN_AF = 2'b10,
		GPODC_FN_ANALOG = 2'b11
	} gpodc_fn_e;
	// decoded slew speed delivered to the pad
	typedef enum logic [1:0] {
		GPODC_SPD_2M = 2'b00,
		GPODC_SPD_10M = 2'b01,
		GPODC_SPD_50M = 2'b10
	} gpodc_speed_e;
	typedef logic [31:0] gpodc_word_t;

	// merge write data into a register on the enabled byte lanes only
	function automatic gpodc_word_t gpodc_merge(input gpodc_word_t old_v, input gpodc_word_t new_v,
		input logic [3:0] be);
		gpodc_word_t res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction : gpodc_merge

	// decode one two-bit speed field
	function automatic gpodc_speed_e gpodc_speed(input logic [1:0] code);
		gpodc_speed_e res;
		res = GPODC_SPD_2M;
		if (code == 2'b01) begin
			res = GPODC_SPD_10M;
		end else if (code == 2'b11) begin
			res = GPODC_SPD_50M;
		end
		return res;
	endfunction : gpodc_speed
endpackage : gpodc_pkg
`default_nettype wire

// >>> src/gpodc_pad_if.sv
// settings and data carried from the register file to the pad driver
`timescale 1ns/1ps
`default_nettype none
interface gpodc_pad_if;
	logic [15:0] drive_type;
	logic [31:0] slew_speed;
	logic [31:0] pin_function;
	logic [15:0] out_data;
	logic [15:0] af_data;
	modport regs (output drive_type, output slew_speed, output pin_function, output out_data, output af_data);
	modport pads (input drive_type, input slew_speed, input pin_function, input out_data, input af_data);
endinterface : gpodc_pad_if
`default_nettype wire

// >>> src/gpodc_pad_drv.sv
// per-pin pad driver control: output enable, level and slew
`timescale 1ns/1ps
`default_nettype none
`include "gpodc_cfg.svh"
module gpodc_pad_drv (
	input wire logic i_clock,
	input wire logic i_rst,
	gpodc_pad_if.pads cfg,
	output logic [15:0] o_pad_out,
	output logic [15:0] o_pad_oe,
	output logic [31:0] o_pad_slew
);
	import gpodc_pkg::*;

	// ****************************************
	// pad control registers
	// ****************************************
	logic [15:0] out_d;
	logic [15:0] oe_d;
	logic [31:0] slew_d;

	// pick data source and driver style per pin
	always_comb begin
		logic [1:0] fn;
		logic dat;
		fn = 2'b00;
		dat = 1'b0;
		out_d = '0;
		oe_d = '0;
		slew_d = '0;
		for (int y = 0; y < `GPODC_PINS; y++) begin
			fn = cfg.pin_function[2*y +: 2];
			dat = (fn == GPODC_FN_AF) ? cfg.af_data[y] : cfg.out_data[y];
			if (fn == GPODC_FN_GPO || fn == GPODC_FN_AF) begin // [R12]
				slew_d[2*y +: 2] = gpodc_speed(cfg.slew_speed[2*y +: 2]); // [R8] [R9]
				if (cfg.drive_type[y] == `GPODC_OD_BIT) begin // [R3] [R4]
					oe_d[y] = ~dat; // [R10]
				end else begin
					oe_d[y] = 1'b1; // [R11]
					out_d[y] = dat;
				end
			end
		end
	end

	// register pad controls; buffer stays off during reset
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_pad_out <= 16'h0000;
			o_pad_oe <= 16'h0000;
			o_pad_slew <= 32'h0000_0000;
		end else begin
			o_pad_out <= out_d;
			o_pad_oe <= oe_d;
			o_pad_slew <= slew_d;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	for (genvar k = 0; k < `GPODC_PINS; k++) begin : g_chk
		chk_od_low_release: assert property (@(posedge i_clock) disable iff (i_rst) // [R10]
			(cfg.pin_function[2*k +: 2] == GPODC_FN_GPO && cfg.drive_type[k])
			|=> (o_pad_oe[k] == ~$past(cfg.out_data[k]) && !o_pad_out[k]))
			else $error("open-drain pin not pulled low or released");
		chk_pp_level: assert property (@(posedge i_clock) disable iff (i_rst) // [R11]
			(cfg.pin_function[2*k +: 2] == GPODC_FN_GPO && !cfg.drive_type[k])
			|=> (o_pad_oe[k] && o_pad_out[k] == $past(cfg.out_data[k])))
			else $error("push-pull pin not driven to data level");
		chk_off_mode: assert property (@(posedge i_clock) disable iff (i_rst) // [R12]
			(cfg.pin_function[2*k] == cfg.pin_function[2*k+1]) |=> !o_pad_oe[k])
			else $error("output buffer on in input or analog mode");
		chk_speed_decode: assert property (@(posedge i_clock) disable iff (i_rst) // [R9]
			(cfg.pin_function[2*k +: 2] == GPODC_FN_AF && cfg.slew_speed[2*k +: 2] == 2'b11)
			|=> o_pad_slew[2*k +: 2] == GPODC_SPD_50M)
			else $error("speed code 11 not decoded as 50 MHz");
	end
endmodule : gpodc_pad_drv
`default_nettype wire

// >>> src/gpodc_top.sv
// gpio output drive configuration: avalon-mm register file and pad control
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "gpodc_cfg.svh"
module gpodc_top #(
	parameter bit PORT_IS_A = 1'b1
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [3:0] i_avs_byteenable,
	input wire gpodc_pkg::gpodc_word_t i_avs_writedata,
	output gpodc_pkg::gpodc_word_t o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [31:0] i_pin_function,
	input wire logic [15:0] i_out_data,
	input wire logic [15:0] i_af_data,
	output logic [15:0] o_pad_out,
	output logic [15:0] o_pad_oe,
	output logic [31:0] o_pad_slew,
	output logic [15:0] o_drive_type,
	output logic [31:0] o_slew_speed
);
	import gpodc_pkg::*;

	// ****************************************
	// bus slave handshake
	// ****************************************
	// one wait cycle per access keeps read data registered ahead of the accepting edge
	logic commit;
	logic req;
	gpodc_word_t rd_d;
	gpodc_word_t drive_q;
	gpodc_word_t slew_q;

	assign req = i_avs_read | i_avs_write;
	assign commit = req & ~o_avs_waitrequest;

	// read mux; unmapped addresses read zero
	always_comb begin
		case (i_avs_address)
			`GPODC_OFS_DRIVE: rd_d = drive_q & `GPODC_DRIVE_MASK; // [R13]
			`GPODC_OFS_SLEW: rd_d = slew_q;
			default: rd_d = `GPODC_RD_ZERO;
		endcase
	end

	// waitrequest drops for exactly the accepting cycle
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_avs_waitrequest <= 1'b1;
		end else begin
			o_avs_waitrequest <= ~(req & o_avs_waitrequest);
		end
	end

	// read data loaded during the wait cycle, stable at the accepting edge
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_avs_readdata <= `GPODC_RD_ZERO;
		end else if (req & o_avs_waitrequest) begin
			o_avs_readdata <= rd_d;
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	// drive type; upper half never stored so it cannot leak to a read
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			drive_q <= `GPODC_DRIVE_RST; // [R1]
		end else if (commit & i_avs_write & (i_avs_address == `GPODC_OFS_DRIVE)) begin // [R1] [R6]
			drive_q <= gpodc_merge(drive_q, i_avs_writedata, i_avs_byteenable) & `GPODC_DRIVE_MASK; // [R2] [R13]
		end
	end

	// slew speed; port a powers up with debug pin 13 at the fast setting
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			slew_q <= PORT_IS_A ? `GPODC_SLEW_RST_A : `GPODC_SLEW_RST; // [R7]
		end else if (commit & i_avs_write & (i_avs_address == `GPODC_OFS_SLEW)) begin // [R7] [R6]
			slew_q <= gpodc_merge(slew_q, i_avs_writedata, i_avs_byteenable); // [R2] [R8]
		end
	end

	// raw register view for other logic of the port
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_drive_type <= 16'h0000;
			o_slew_speed <= 32'h0000_0000;
		end else begin
			o_drive_type <= drive_q[15:0]; // [R3]
			o_slew_speed <= slew_q;
		end
	end

	// ****************************************
	// pad driver
	// ****************************************
	gpodc_pad_if pad_cfg ();
	assign pad_cfg.drive_type = drive_q[15:0];
	assign pad_cfg.slew_speed = slew_q;
	assign pad_cfg.pin_function = i_pin_function;
	assign pad_cfg.out_data = i_out_data;
	assign pad_cfg.af_data = i_af_data;

	gpodc_pad_drv u_pad_drv (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.cfg(pad_cfg),
		.o_pad_out(o_pad_out),
		.o_pad_oe(o_pad_oe),
		.o_pad_slew(o_pad_slew)
	);

	// ****************************************
	// checks
	// ****************************************
	// looked at on the first edge after release, so the very first edge of the run cannot see an unset register
	chk_drive_reset_zero: assert property (@(posedge i_clock) // [R1]
		($past(i_rst) && !i_rst) |-> drive_q == `GPODC_DRIVE_RST)
		else $error("drive type not zero after reset");
	chk_slew_reset_val: assert property (@(posedge i_clock) // [R7]
		($past(i_rst) && !i_rst) |-> slew_q == (PORT_IS_A ? `GPODC_SLEW_RST_A : `GPODC_SLEW_RST))
		else $error("speed register wrong after reset");
	chk_upper_zero: assert property (@(posedge i_clock) disable iff (i_rst) // [R13]
		(commit & i_avs_read & (i_avs_address == `GPODC_OFS_DRIVE)) |-> o_avs_readdata[31:16] == 16'h0000)
		else $error("drive type upper half reads non-zero");
	chk_byte_lanes: assert property (@(posedge i_clock) disable iff (i_rst) // [R2]
		(commit & i_avs_write & (i_avs_address == `GPODC_OFS_SLEW) & !i_avs_byteenable[3])
		|=> slew_q[31:24] == $past(slew_q[31:24]))
		else $error("disabled byte lane of speed register changed");
	chk_write_lands: assert property (@(posedge i_clock) disable iff (i_rst) // [R2]
		(commit & i_avs_write & (i_avs_address == `GPODC_OFS_DRIVE) & i_avs_byteenable[0])
		|=> drive_q[7:0] == $past(i_avs_writedata[7:0]))
		else $error("enabled byte lane of drive type not written");
	chk_hold_value: assert property (@(posedge i_clock) disable iff (i_rst) // [R6]
		!(commit & i_avs_write) |=> $stable(drive_q) && $stable(slew_q))
		else $error("configuration changed without a write");
	chk_wait_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
		(req & o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
		else $error("waitrequest not low for exactly one cycle");
endmodule : gpodc_top
`default_nettype wire

// >>> test/tb_gpodc_top.sv
// self-checking bench for the gpio output drive configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_gpodc_top;
	import gpodc_pkg::*;
	// ****************************************
	// stimulus and observed signals
	// ****************************************
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] i_avs_address = 8'h00;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [3:0] i_avs_byteenable = 4'h0;
	gpodc_word_t i_avs_writedata = 32'h0;
	logic [31:0] i_pin_function = 32'h0;
	logic [15:0] i_out_data = 16'h0;
	logic [15:0] i_af_data = 16'h0;
	gpodc_word_t o_avs_readdata;
	logic o_avs_waitrequest;
	logic [15:0] o_pad_out;
	logic [15:0] o_pad_oe;
	logic [15:0] o_drive_type;
	logic [31:0] o_pad_slew;
	logic [31:0] o_slew_speed;
	int miscompares = 0;
	int n_checks = 0;
	gpodc_word_t rd;
	// set once a bus wait runs out; later accesses stop waiting so the run reaches its report quickly
	bit hung = 1'b0;

	// port A build, so the speed register has its non-zero default
	gpodc_top #(.PORT_IS_A(1'b1)) i_gpodc_top (.i_clock, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
		.i_avs_byteenable, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_pin_function,
		.i_out_data, .i_af_data, .o_pad_out, .o_pad_oe, .o_pad_slew, .o_drive_type, .o_slew_speed);

	// 200 MHz clock
	always #2.5 i_clock = ~i_clock;

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict

	// one avalon access; request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge i_clock);
		i_avs_address <= a;
		i_avs_read <= !wr;
		i_avs_write <= wr;
		i_avs_writedata <= d;
		i_avs_byteenable <= be;
		do begin
			@(posedge i_clock);
			n++;
			if (n > 20) begin
				miscompares++;
				hung = 1'b1;
			end
		end while (!hung && o_avs_waitrequest !== 1'b0);
		rd = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask : bus

	task automatic do_reset;
		@(posedge i_clock);
		i_rst <= 1'b1;
		repeat (12) @(posedge i_clock);
		i_rst <= 1'b0;
	endtask : do_reset

	// expected pad state {oe, out, slew} worked out per pin
	function automatic logic [63:0] pad_exp(input logic [31:0] fn, input logic [15:0] od, input logic [31:0] spd);
		logic [15:0] oe;
		logic [15:0] out;
		logic [31:0] sl;
		logic [1:0] m;
		logic dat;
		oe = 16'h0;
		out = 16'h0;
		sl = 32'h0;
		for (int y = 0; y < 16; y++) begin
			m = fn[2*y +: 2];
			dat = (m == 2'b10) ? i_af_data[y] : i_out_data[y];
			if (m == 2'b01 || m == 2'b10) begin
				oe[y] = od[y] ? !dat : 1'b1;
				out[y] = od[y] ? 1'b0 : dat;
				sl[2*y +: 2] = !spd[2*y] ? 2'b00 : (spd[2*y+1] ? 2'b10 : 2'b01);
			end
		end
		return {oe, out, sl};
	endfunction : pad_exp

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset_values;
		bus(1'b0, 8'h04, 32'h0, 4'h0);
		chk(rd, 32'h0000_0000);
		bus(1'b0, 8'h08, 32'h0, 4'h0);
		chk(rd, 32'h0C00_0000);
		chk(o_slew_speed, 32'h0C00_0000);
		chk({16'h0, o_drive_type}, 32'h0000_0000);
		$display("test reset values done");
	endtask : t_reset_values

	task automatic t_byte_lanes;
		bus(1'b1, 8'h08, 32'hFFFF_FFFF, 4'hF);
		bus(1'b1, 8'h08, 32'h1234_5678, 4'h2);
		bus(1'b0, 8'h08, 32'h0, 4'h0);
		chk(rd, 32'hFFFF_56FF);
		bus(1'b1, 8'h08, 32'h9999_ABCD, 4'h3);
		bus(1'b0, 8'h08, 32'h0, 4'h0);
		chk(rd, 32'hFFFF_ABCD);
		chk(o_slew_speed, 32'hFFFF_ABCD);
		bus(1'b1, 8'h04, 32'h0000_FFFF, 4'hF);
		bus(1'b0, 8'h04, 32'h0, 4'h0);
		chk(rd, 32'h0000_FFFF);
		bus(1'b1, 8'h04, 32'h0000_0000, 4'h1);
		bus(1'b0, 8'h04, 32'h0, 4'h0);
		chk(rd, 32'h0000_FF00);
		chk({16'h0, o_drive_type}, 32'h0000_FF00);
		$display("test byte lanes done");
	endtask : t_byte_lanes

	// an unmapped place reads zero; unmapped and misaligned writes leave registers alone
	task automatic t_unmapped_hold;
		bus(1'b1, 8'h0C, 32'hFFFF_FFFF, 4'hF);
		bus(1'b1, 8'h05, 32'h0000_0000, 4'hF);
		bus(1'b0, 8'h0C, 32'h0, 4'h0);
		chk(rd, 32'h0000_0000);
		repeat (50) @(posedge i_clock);
		bus(1'b0, 8'h04, 32'h0, 4'h0);
		chk(rd, 32'h0000_FF00);
		bus(1'b0, 8'h08, 32'h0, 4'h0);
		chk(rd, 32'hFFFF_ABCD);
		$display("test unmapped and hold done");
	endtask : t_unmapped_hold

	// every function mode, mixed drive types and every speed code
	task automatic t_pad_modes;
		logic [31:0] fns [5];
		logic [63:0] e;
		fns = '{32'h0000_0000, 32'h5555_5555, 32'hAAAA_AAAA, 32'hFFFF_FFFF, 32'h1B1B_1B1B};
		bus(1'b1, 8'h04, 32'h0000_0F0F, 4'hF);
		bus(1'b1, 8'h08, 32'hE4E4_E4E4, 4'hF);
		for (int k = 0; k < 5; k++) begin
			@(posedge i_clock);
			i_pin_function <= fns[k];
			i_out_data <= 16'h5A3C;
			i_af_data <= 16'hC3A5;
			repeat (3) @(posedge i_clock);
			#1;
			e = pad_exp(fns[k], 16'h0F0F, 32'hE4E4_E4E4);
			chk({16'h0, o_pad_oe}, {16'h0, e[63:48]});
			chk({16'h0, o_pad_out}, {16'h0, e[47:32]});
			chk(o_pad_slew, e[31:0]);
		end
		$display("test pad modes done");
	endtask : t_pad_modes

	// ****************************************
	// main sequence, with a second reset after traffic
	// ****************************************
	initial begin
		do_reset();
		t_reset_values();
		t_byte_lanes();
		t_unmapped_hold();
		t_pad_modes();
		do_reset();
		t_reset_values();
		print_verdict();
	end
endmodule : tb_gpodc_top
`default_nettype wire
